//--- rtl/dmsep_pkg.sv
/*
 * shared constants and types for the dual mode serial eeprom port.
 * assumes a 25 MHz system clock on both ends.
 */
package dmsep_pkg;
  localparam int unsigned DMSEP_CLK_HZ = 25000000;
  localparam int unsigned DMSEP_AW = 7;
  localparam int unsigned DMSEP_DEPTH = 128;
  localparam logic [3:0] DMSEP_DEV_CODE = 4'ha;
  localparam logic [6:0] DMSEP_ADDR_TOP = 7'h7f;
  localparam logic [6:0] DMSEP_ADDR_ZERO = 7'h00;
  localparam int unsigned DMSEP_INIT_CLOCKS = 9;
  localparam int unsigned DMSEP_INIT_SAMPLE = 8;
  // program_cycle_time, in microseconds
  localparam int unsigned DMSEP_PROGRAM_CYCLE_TIME_US = 5000;
  localparam int unsigned DMSEP_PROGRAM_CYCLE_CYC =
    DMSEP_PROGRAM_CYCLE_TIME_US * (DMSEP_CLK_HZ / 1000000);
  // power_up_write_delay, in microseconds
  localparam int unsigned DMSEP_POWER_UP_WRITE_DELAY_US = 1000;
  localparam int unsigned DMSEP_POWER_UP_CYC =
    DMSEP_POWER_UP_WRITE_DELAY_US * (DMSEP_CLK_HZ / 1000000);
  // host divider for transmit_only_clock half periods and scl quarter periods
  localparam int unsigned DMSEP_HALF_CYC = 20;
  typedef enum logic [1:0] {DMSEP_OP_TXO, DMSEP_OP_WRITE, DMSEP_OP_READ} dmsep_op_t;
endpackage

//--- rtl/dmsep_if.sv
/*
 * link pins between host and eeprom end.
 * open-drain sda resolved here; scl and transmit_only_clock driven by host.
 */
`timescale 1ns/1ps
interface dmsep_if;
  logic scl;
  logic transmit_only_clock;
  logic sda_dev_oe;
  logic sda_host_oe;
  logic sda;
  // wired-and with pull-up
  assign sda = !(sda_dev_oe || sda_host_oe);
  modport dev (input scl, input transmit_only_clock, input sda, output sda_dev_oe);
  modport host (output scl, output transmit_only_clock, input sda, output sda_host_oe);
endinterface

//--- rtl/dmsep_dev.sv
/*
 * eeprom end: transmit-only streamer and two-wire slave over one array.
 * assumes rst stands for power-up and the link pins are asynchronous.
 */
// Summary of operation
// - powers up streaming bytes on transmit clock
// - scl falling edge switches to bidirectional
// - bidirectional mode is permanent until reset
// - writes blocked while transmit clock low
// - transmit clock only level in bidirectional
// - no data before nine init clocks
// - sda high at init gives 7fh start
// - sda released on ninth init clock
// - msb first, ninth bit released
// - stream whole array wrapping 7fh to 00h
// - host holds scl high while streaming
// - master starts only on idle bus
// - sda change under scl high is condition
// - start detected; traffic ignored before it
// - stop detected, ends every operation
// - match upper nibble 1010, ignore three
// - last address bit selects read
// - ack matching address then transfer
// - program cycle after write stop, deaf
// - host waits before first access
// - sda only pulled low
// - read releases, checks master ack
// - ack every written byte
`timescale 1ns/1ps
module dmsep_dev #(
  parameter int unsigned PROG_CYC = dmsep_pkg::DMSEP_PROGRAM_CYCLE_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // link
  dmsep_if.dev lnk,
  // user status
  output logic bidir_mode,
  output logic prog_busy
);
  import dmsep_pkg::*;
  //////////////////////////////////////////////////////////////////////
  logic [DMSEP_AW-1:0] ptr_r, ptr_nxt;
  logic [7:0] mem [DMSEP_DEPTH];
  logic [1:0] scl_s, vck_s, sda_s;
  logic scl_d, vck_d, sda_d;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      scl_s <= 2'h3;
      vck_s <= 2'h0;
      sda_s <= 2'h3;
      scl_d <= 1'b1;
      vck_d <= 1'b0;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_s <= {scl_s[0], lnk.scl};
      vck_s <= {vck_s[0], lnk.transmit_only_clock};
      sda_s <= {sda_s[0], lnk.sda};
      scl_d <= scl_s[1];
      vck_d <= vck_s[1];
      sda_d <= sda_s[1];
    end
  end
  logic scl_rise, scl_fall, vck_rise, vck_fall, start_ev, stop_ev;
  always_comb
  begin
    scl_rise = scl_s[1] && !scl_d;
    scl_fall = !scl_s[1] && scl_d;
    vck_rise = vck_s[1] && !vck_d;
    vck_fall = !vck_s[1] && vck_d;
    start_ev = scl_s[1] && scl_d && sda_d && !sda_s[1];
    stop_ev = scl_s[1] && scl_d && !sda_d && sda_s[1];
  end
  //////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {DMSEP_IDLE, DMSEP_ADDR, DMSEP_RX, DMSEP_TX, DMSEP_ACKO,
    DMSEP_ACKI, DMSEP_WAITSTOP} dmsep_st_t;
  dmsep_st_t st_r, st_nxt;
  logic bidir_r, bidir_nxt, oe_r, oe_nxt, init_r, init_nxt, rd_r, rd_nxt;
  logic have_ptr_r, have_ptr_nxt, wrote_r, wrote_nxt, sel_r, sel_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [22:0] prog_r, prog_nxt;
  logic hi_seen_r, hi_seen_nxt;
  logic mem_we;
  logic [7:0] mem_wd;
  always_comb
  begin
    st_nxt = st_r;
    bidir_nxt = bidir_r;
    oe_nxt = oe_r;
    init_nxt = init_r;
    rd_nxt = rd_r;
    have_ptr_nxt = have_ptr_r;
    wrote_nxt = wrote_r;
    sel_nxt = sel_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    prog_nxt = prog_r;
    hi_seen_nxt = hi_seen_r;
    mem_we = 1'b0;
    mem_wd = sh_r;
    if (prog_r != 23'h0)
      prog_nxt = prog_r - 23'h1;
    if (!bidir_r)
    begin
      // transmit-only streaming, timed on transmit clock edges
      if (scl_fall)
      begin
        bidir_nxt = 1'b1;
        oe_nxt = 1'b0;
        st_nxt = DMSEP_IDLE;
        bit_nxt = 4'h0;
      end
      else if (vck_rise && init_r)
      begin
        if (bit_r < 4'(DMSEP_INIT_SAMPLE))
          hi_seen_nxt = hi_seen_r | sda_d;
      end
      else if (vck_rise)
      begin
        if (bit_r == 4'h8)
          ptr_nxt = ptr_r + 7'h1;
      end
      else if (vck_fall && init_r)
      begin
        oe_nxt = 1'b0;
        if (bit_r == 4'(DMSEP_INIT_CLOCKS - 1))
        begin
          init_nxt = 1'b0;
          bit_nxt = 4'h0;
          ptr_nxt = hi_seen_r ? DMSEP_ADDR_TOP : DMSEP_ADDR_ZERO;
          oe_nxt = !mem[hi_seen_r ? DMSEP_ADDR_TOP : DMSEP_ADDR_ZERO][7];
        end
        else
          bit_nxt = bit_r + 4'h1;
      end
      else if (vck_fall)
      begin
        // drive next bit msb first; ninth slot released
        bit_nxt = (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
        if (bit_r == 4'h7)
          oe_nxt = 1'b0;
        else if (bit_r == 4'h8)
          oe_nxt = !mem[ptr_r][7];
        else
          oe_nxt = !mem[ptr_r][3'(6 - bit_r)];
      end
    end
    else if (start_ev && prog_r == 23'h0)
    begin
      st_nxt = DMSEP_ADDR;
      bit_nxt = 4'h0;
      oe_nxt = 1'b0;
      have_ptr_nxt = 1'b0;
    end
    else if (stop_ev)
    begin
      if (wrote_r)
        prog_nxt = 23'(PROG_CYC);
      wrote_nxt = 1'b0;
      st_nxt = DMSEP_IDLE;
      oe_nxt = 1'b0;
    end
    else if (st_r != DMSEP_IDLE && prog_r == 23'h0)
    begin
      // bidirectional mode ignores transmit clock edges
      if (scl_rise && (st_r == DMSEP_ADDR || st_r == DMSEP_RX))
      begin
        sh_nxt = {sh_r[6:0], sda_d};
        bit_nxt = bit_r + 4'h1;
      end
      else if (scl_rise && st_r == DMSEP_ACKI)
        sel_nxt = !sda_d;
      if (scl_fall)
      begin
        case (st_r)
          DMSEP_ADDR:
            if (bit_r == 4'h8)
            begin
              if (sh_r[7:4] == DMSEP_DEV_CODE)
              begin
                rd_nxt = sh_r[0];
                oe_nxt = 1'b1;
                st_nxt = DMSEP_ACKO;
              end
              else
                st_nxt = DMSEP_IDLE;
            end
          DMSEP_RX:
            if (bit_r == 4'h8)
            begin
              oe_nxt = 1'b1;
              st_nxt = DMSEP_ACKO;
              if (!have_ptr_r)
              begin
                ptr_nxt = sh_r[6:0];
                have_ptr_nxt = 1'b1;
              end
              else if (vck_s[1])
              begin
                mem_we = 1'b1;
                wrote_nxt = 1'b1;
                ptr_nxt = ptr_r + 7'h1;
              end
            end
          DMSEP_ACKO:
          begin
            bit_nxt = 4'h0;
            if (rd_r)
            begin
              st_nxt = DMSEP_TX;
              oe_nxt = !mem[ptr_r][7];
            end
            else
            begin
              st_nxt = DMSEP_RX;
              oe_nxt = 1'b0;
            end
          end
          DMSEP_TX:
            if (bit_r == 4'h7)
            begin
              oe_nxt = 1'b0;
              ptr_nxt = ptr_r + 7'h1;
              st_nxt = DMSEP_ACKI;
            end
            else
            begin
              bit_nxt = bit_r + 4'h1;
              oe_nxt = !mem[ptr_r][3'(6 - bit_r)];
            end
          DMSEP_ACKI:
            if (sel_r)
            begin
              bit_nxt = 4'h0;
              st_nxt = DMSEP_TX;
              oe_nxt = !mem[ptr_r][7];
            end
            else
              st_nxt = DMSEP_WAITSTOP;
          default:
            st_nxt = st_r;
        endcase
      end
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_r <= DMSEP_IDLE;
      bidir_r <= 1'b0;
      oe_r <= 1'b0;
      init_r <= 1'b1;
      rd_r <= 1'b0;
      have_ptr_r <= 1'b0;
      wrote_r <= 1'b0;
      sel_r <= 1'b0;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 7'h00;
      prog_r <= 23'h0;
      hi_seen_r <= 1'b0;
      bidir_mode <= 1'b0;
      prog_busy <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      bidir_r <= bidir_nxt;
      oe_r <= oe_nxt;
      init_r <= init_nxt;
      rd_r <= rd_nxt;
      have_ptr_r <= have_ptr_nxt;
      wrote_r <= wrote_nxt;
      sel_r <= sel_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      prog_r <= prog_nxt;
      hi_seen_r <= hi_seen_nxt;
      bidir_mode <= bidir_nxt;
      prog_busy <= (prog_nxt != 23'h0);
    end
  end
  // array contents survive reset, as nonvolatile storage would
  always_ff @(posedge sys_clk)
  begin
    if (mem_we)
      mem[ptr_r] <= mem_wd;
  end
  assign lnk.sda_dev_oe = oe_r;
endmodule

//--- rtl/dmsep_host.sv
/*
 * host end: streams in transmit-only mode, then runs two-wire transfers.
 * assumes one request at a time from the user side.
 */
`timescale 1ns/1ps
module dmsep_host #(
  parameter int unsigned PWR_CYC = dmsep_pkg::DMSEP_POWER_UP_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // link
  dmsep_if.host lnk,
  // request
  input wire logic req,
  input wire dmsep_pkg::dmsep_op_t req_op,
  input wire logic [6:0] req_addr,
  input wire logic [7:0] req_data,
  input wire logic wr_enable,
  // answer
  output logic busy,
  output logic done,
  output logic nack,
  output logic [7:0] rd_data
);
  import dmsep_pkg::*;
  //////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {DMSEP_H_IDLE, DMSEP_H_BIT, DMSEP_H_END} dmsep_hst_t;
  dmsep_hst_t st_r, st_nxt;
  logic [1:0] sda_s;
  logic [22:0] pwr_r, pwr_nxt;
  logic [5:0] div_r, div_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [5:0] idx_r, idx_nxt;
  logic [5:0] len_r, len_nxt;
  logic [35:0] seq_r, seq_nxt;
  // data byte plus the trailing no-ack sample
  logic [8:0] rx_r, rx_nxt;
  logic scl_r, scl_nxt, vck_r, vck_nxt, oe_r, oe_nxt, nk_r, nk_nxt, dn_nxt;
  logic txo_r, txo_nxt;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      sda_s <= 2'h3;
    else
      sda_s <= {sda_s[0], lnk.sda};
  end
  // frames: start, 9-bit slots (ack slot 1 = release), stop
  always_comb
  begin
    st_nxt = st_r;
    pwr_nxt = (pwr_r != 23'h0) ? pwr_r - 23'h1 : pwr_r;
    div_nxt = div_r;
    ph_nxt = ph_r;
    idx_nxt = idx_r;
    len_nxt = len_r;
    seq_nxt = seq_r;
    rx_nxt = rx_r;
    scl_nxt = scl_r;
    vck_nxt = wr_enable;
    oe_nxt = oe_r;
    nk_nxt = nk_r;
    dn_nxt = 1'b0;
    txo_nxt = txo_r;
    case (st_r)
      DMSEP_H_IDLE:
      begin
        if (req && req_op == DMSEP_OP_TXO)
        begin
          txo_nxt = 1'b1;
          div_nxt = 6'h0;
        end
        if (txo_r)
        begin
          // free-running transmit clock; the device does the rest
          div_nxt = div_r + 6'h1;
          if (div_r == 6'(DMSEP_HALF_CYC - 1))
          begin
            div_nxt = 6'h0;
            vck_nxt = !vck_r;
          end
          else
            vck_nxt = vck_r;
        end
        if (req && req_op != DMSEP_OP_TXO && pwr_r == 23'h0 && sda_s[1] && scl_r)
        begin
          txo_nxt = 1'b0;
          oe_nxt = 1'b1; // start
          nk_nxt = 1'b0;
          idx_nxt = 6'h0;
          div_nxt = 6'h0;
          ph_nxt = 2'h0;
          if (req_op == DMSEP_OP_WRITE)
          begin
            seq_nxt = {DMSEP_DEV_CODE, 4'h0, 1'b1, 1'b0, req_addr, 1'b1, req_data, 1'b1, 9'h0};
            len_nxt = 6'd27;
          end
          else
          begin
            seq_nxt = {DMSEP_DEV_CODE, 4'h1, 1'b1, 8'hff, 1'b1, 18'h0};
            len_nxt = 6'd18;
          end
          st_nxt = DMSEP_H_BIT;
        end
      end
      DMSEP_H_BIT:
      begin
        div_nxt = div_r + 6'h1;
        if (div_r == 6'(DMSEP_HALF_CYC - 1))
        begin
          div_nxt = 6'h0;
          ph_nxt = ph_r + 2'h1;
          case (ph_r)
            2'h0:
            begin
              scl_nxt = 1'b0;
            end
            2'h1:
            begin
              oe_nxt = !seq_r[35];
            end
            2'h2:
            begin
              scl_nxt = 1'b1;
            end
            default:
            begin
              rx_nxt = {rx_r[7:0], sda_s[1]};
              if (idx_r == 6'd8 && sda_s[1])
                nk_nxt = 1'b1;
              if (idx_r == 6'd17 && sda_s[1] && len_r == 6'd27)
                nk_nxt = 1'b1;
              if (idx_r == 6'd26 && sda_s[1])
                nk_nxt = 1'b1;
              seq_nxt = {seq_r[34:0], 1'b1};
              idx_nxt = idx_r + 6'h1;
              if (idx_r + 6'h1 == len_r || (idx_r == 6'd8 && sda_s[1]))
              begin
                st_nxt = DMSEP_H_END;
                ph_nxt = 2'h0;
              end
            end
          endcase
        end
      end
      default:
      begin
        // stop: scl low, sda low, scl high, sda released
        div_nxt = div_r + 6'h1;
        if (div_r == 6'(DMSEP_HALF_CYC - 1))
        begin
          div_nxt = 6'h0;
          ph_nxt = ph_r + 2'h1;
          case (ph_r)
            2'h0: scl_nxt = 1'b0;
            2'h1: oe_nxt = 1'b1;
            2'h2: scl_nxt = 1'b1;
            default:
            begin
              oe_nxt = 1'b0;
              dn_nxt = 1'b1;
              st_nxt = DMSEP_H_IDLE;
            end
          endcase
        end
      end
    endcase
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_r <= DMSEP_H_IDLE;
      pwr_r <= 23'(PWR_CYC);
      div_r <= 6'h0;
      ph_r <= 2'h0;
      idx_r <= 6'h0;
      len_r <= 6'h0;
      seq_r <= 36'h0;
      rx_r <= 9'h000;
      scl_r <= 1'b1;
      vck_r <= 1'b0;
      oe_r <= 1'b0;
      nk_r <= 1'b0;
      txo_r <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      nack <= 1'b0;
      rd_data <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
      pwr_r <= pwr_nxt;
      div_r <= div_nxt;
      ph_r <= ph_nxt;
      idx_r <= idx_nxt;
      len_r <= len_nxt;
      seq_r <= seq_nxt;
      rx_r <= rx_nxt;
      scl_r <= scl_nxt;
      vck_r <= vck_nxt;
      oe_r <= oe_nxt;
      nk_r <= nk_nxt;
      txo_r <= txo_nxt;
      busy <= (st_nxt != DMSEP_H_IDLE);
      done <= dn_nxt;
      nack <= dn_nxt ? nk_nxt : nack;
      rd_data <= (dn_nxt && len_r == 6'd18) ? rx_r[8:1] : rd_data;
    end
  end
  assign lnk.scl = scl_r;
  assign lnk.transmit_only_clock = vck_r;
  assign lnk.sda_host_oe = oe_r;
endmodule

//--- verif/dmsep_props.sv
/*
 * link checker for the dual mode serial eeprom port, watching the shared pins.
 * assumes one sys_clk domain, sync active-high rst and a pull-up on sda.
 */
`timescale 1ns/1ps
module dmsep_props #(
  parameter int unsigned PROG = 2000,
  parameter int unsigned PWR = 50
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // link
  input wire logic scl,
  input wire logic transmit_only_clock,
  input wire logic sda_dev_oe,
  input wire logic sda_host_oe,
  input wire logic sda
);
  import dmsep_pkg::*;
  logic scl_r, sda_r, toc_r, srise, start, stop, vrise;
  logic bidir_r, bidir_nxt, act_r, act_nxt, first_r, first_nxt, wr_r, wr_nxt;
  logic [3:0] bit_r, bit_nxt, vcnt_r, vcnt_nxt, slot_r, slot_nxt;
  logic [7:0] byte_r, byte_nxt;
  logic [15:0] pwr_r, pwr_nxt, prog_r, prog_nxt;

  ////////////////////////////////////////////////////////////////////////////
  assign srise = scl && !scl_r;
  assign vrise = transmit_only_clock && !toc_r;
  // only host-made starts: streaming toggles sda under a high scl
  assign start = bidir_r && scl && scl_r && sda_r && !sda && sda_host_oe;
  assign stop = bidir_r && scl && scl_r && !sda_r && sda;

  always_ff @(posedge sys_clk)
  begin
    scl_r <= scl;
    sda_r <= sda;
    toc_r <= transmit_only_clock;
  end

  always_comb
  begin
    bidir_nxt = bidir_r || (scl_r && !scl);
    act_nxt = act_r;
    first_nxt = first_r;
    wr_nxt = wr_r;
    bit_nxt = bit_r;
    byte_nxt = byte_r;
    vcnt_nxt = vcnt_r;
    slot_nxt = slot_r;
    pwr_nxt = (pwr_r < PWR) ? pwr_r + 16'h1 : pwr_r;
    prog_nxt = (prog_r != 16'h0) ? prog_r - 16'h1 : prog_r;
    if (start)
    begin
      act_nxt = 1'b1;
      first_nxt = 1'b1;
      bit_nxt = 4'h0;
    end
    else if (stop)
    begin
      act_nxt = 1'b0;
      // protected writes never start a program cycle
      if (act_r && wr_r && !first_r && transmit_only_clock)
        prog_nxt = 16'(PROG);
    end
    else if (srise && act_r && bit_r == 4'h8)
    begin
      bit_nxt = 4'h0;
      first_nxt = 1'b0;
      if (first_r)
        wr_nxt = !byte_r[0];
    end
    else if (srise && act_r)
    begin
      byte_nxt = {byte_r[6:0], sda};
      bit_nxt = bit_r + 4'h1;
    end
    if (vrise && !bidir_r && vcnt_r != 4'h9)
      vcnt_nxt = vcnt_r + 4'h1;
    else if (vrise && !bidir_r)
      slot_nxt = (slot_r == 4'h8) ? 4'h0 : slot_r + 4'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      {bidir_r, act_r, first_r, wr_r, bit_r, byte_r, vcnt_r, slot_r, pwr_r, prog_r} <= '0;
    else
      {bidir_r, act_r, first_r, wr_r, bit_r, byte_r, vcnt_r, slot_r, pwr_r, prog_r} <=
        {bidir_nxt, act_nxt, first_nxt, wr_nxt, bit_nxt, byte_nxt, vcnt_nxt, slot_nxt,
         pwr_nxt, prog_nxt};
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking dmsep_cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_init_quiet: assert property (
    !bidir_r && vcnt_r < 4'h9 |-> !sda_dev_oe) else $error("data driven during init");
  a_txo_slot_free: assert property (
    !bidir_r && vcnt_r == 4'h9 && slot_r == 4'h0 && transmit_only_clock && toc_r
    |-> !sda_dev_oe) else $error("ninth slot not released");
  a_pwr_wait_host: assert property (
    pwr_r < PWR |-> scl && !sda_host_oe) else $error("host active too early");
  a_dev_scl_stable: assert property (
    bidir_r && scl && scl_r |-> $stable(sda_dev_oe)) else $error("sda moved under high scl");
  a_addr_ack_given: assert property (
    act_r && srise && bit_r == 4'h8 && first_r && byte_r[7:4] == DMSEP_DEV_CODE
    && prog_r == 16'h0 |-> !sda) else $error("address not acknowledged");
  a_write_byte_ack: assert property (
    act_r && srise && bit_r == 4'h8 && !first_r && wr_r |-> !sda)
    else $error("write byte not acknowledged");
  a_read_ack_free: assert property (
    act_r && srise && bit_r == 4'h8 && !first_r && !wr_r |-> !sda_dev_oe)
    else $error("read ack slot not released");
  a_start_bus_idle: assert property (
    start |-> !act_r) else $error("start on a busy bus");
  a_prog_deaf: assert property (
    prog_r != 16'h0 |-> !sda_dev_oe) else $error("answered during program cycle");
endmodule

//--- verif/dmsep_tb.sv
/*
 * self-checking bench: host end and eeprom end joined by one link.
 * assumes the array keeps its contents across rst, as over a power cycle.
 */
`timescale 1ns/1ps
module dmsep_tb;
  import dmsep_pkg::*;
  localparam int unsigned PROG = 2000;
  localparam int unsigned PWR = 50;
  typedef struct packed {
    dmsep_op_t op;
    logic [6:0] addr;
    logic [7:0] data;
    logic chk;
    logic [7:0] exp;
  } dmsep_row_t;
  // row 0 only flips the mode; its start may come before the switch
  dmsep_row_t rows [6] = '{
    '{DMSEP_OP_READ, 7'h00, 8'h00, 1'b0, 8'h00},
    '{DMSEP_OP_WRITE, 7'h01, 8'ha5, 1'b1, 8'h00},
    '{DMSEP_OP_WRITE, 7'h00, 8'h3c, 1'b1, 8'h00},
    '{DMSEP_OP_WRITE, 7'h7f, 8'hc9, 1'b1, 8'h00},
    '{DMSEP_OP_READ, 7'h00, 8'h00, 1'b1, 8'h3c},
    '{DMSEP_OP_READ, 7'h00, 8'h00, 1'b1, 8'ha5}};
  logic [7:0] stream [3] = '{8'hc9, 8'h3c, 8'ha5};
  logic sys_clk, rst, req, wr_enable, busy, done, nack, bidir_mode, prog_busy, b;
  dmsep_op_t req_op;
  logic [6:0] req_addr;
  logic [7:0] req_data, rd_data;
  int fail_count, n_tests;

  ////////////////////////////////////////////////////////////////////////////
  dmsep_if dmsep_if_i ();
  dmsep_dev #(.PROG_CYC(PROG)) dmsep_dev_i (.sys_clk(sys_clk), .rst(rst),
    .lnk(dmsep_if_i.dev), .bidir_mode(bidir_mode), .prog_busy(prog_busy));
  dmsep_host #(.PWR_CYC(PWR)) dmsep_host_i (.sys_clk(sys_clk), .rst(rst),
    .lnk(dmsep_if_i.host), .req(req), .req_op(req_op), .req_addr(req_addr),
    .req_data(req_data), .wr_enable(wr_enable), .busy(busy), .done(done), .nack(nack),
    .rd_data(rd_data));
  dmsep_props #(.PROG(PROG), .PWR(PWR)) dmsep_props_i (.sys_clk(sys_clk), .rst(rst),
    .scl(dmsep_if_i.scl), .transmit_only_clock(dmsep_if_i.transmit_only_clock),
    .sda_dev_oe(dmsep_if_i.sda_dev_oe), .sda_host_oe(dmsep_if_i.sda_host_oe),
    .sda(dmsep_if_i.sda));

  always #20 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic stall();
    fail_count++;
    $display("[ERR] %0t wait ran out", $time);
    end_of_test();
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t bit %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t byte %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic issue(input dmsep_op_t op, input logic [6:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_data <= d;
    @(posedge sys_clk);
    req <= 1'b0;
  endtask

  task automatic run(input dmsep_op_t op, input logic [6:0] a, input logic [7:0] d);
    int k;
    issue(op, a, d);
    for (k = 0; k < 20000; k++)
    begin
      @(posedge sys_clk);
      #1;
      if (done === 1'b1)
        break;
    end
    if (k == 20000)
      stall();
    // the stop reaches the eeprom through its synchronisers a few cycles after done
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_prog();
    int k;
    for (k = 0; k < PROG + 500; k++)
    begin
      @(posedge sys_clk);
      #1;
      if (prog_busy === 1'b0)
        break;
    end
    if (k == PROG + 500)
      stall();
  endtask

  // sda taken at a rising transmit clock, half a period after the device shifted
  task automatic get_rise(output logic v);
    int k;
    logic p;
    p = dmsep_if_i.transmit_only_clock;
    for (k = 0; k < 200; k++)
    begin
      @(posedge sys_clk);
      #1;
      if (dmsep_if_i.transmit_only_clock && !p)
        break;
      p = dmsep_if_i.transmit_only_clock;
    end
    if (k == 200)
      stall();
    v = dmsep_if_i.sda;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int i, j;
    sys_clk = 1'b0;
    rst = 1'b1;
    req = 1'b0;
    req_op = DMSEP_OP_READ;
    req_addr = 7'h00;
    req_data = 8'h00;
    wr_enable = 1'b1;
    fail_count = 0;
    n_tests = 0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    issue(DMSEP_OP_READ, 7'h00, 8'h00);
    repeat (3) @(posedge sys_clk);
    #1;
    chk_bit(busy, 1'b0);
    chk_bit(bidir_mode, 1'b0);
    $display("early request test finished");
    repeat (PWR) @(posedge sys_clk);
    for (i = 0; i < 6; i++)
    begin
      run(rows[i].op, rows[i].addr, rows[i].data);
      if (rows[i].chk)
        chk_bit(nack, 1'b0);
      if (rows[i].chk && rows[i].op == DMSEP_OP_READ)
        chk_byte(rd_data, rows[i].exp);
      wait_prog();
      $display("row %0d finished", i);
    end
    chk_bit(bidir_mode, 1'b1);
    wr_enable <= 1'b0;
    run(DMSEP_OP_WRITE, 7'h00, 8'h5a);
    chk_bit(nack, 1'b0);
    wait_prog();
    wr_enable <= 1'b1;
    run(DMSEP_OP_WRITE, 7'h7f, 8'hc9);
    chk_bit(prog_busy, 1'b1);
    run(DMSEP_OP_READ, 7'h00, 8'h00);
    chk_bit(nack, 1'b1);
    wait_prog();
    run(DMSEP_OP_READ, 7'h00, 8'h00);
    chk_byte(rd_data, 8'h3c);
    $display("protect and program cycle test finished");
    // transmit clock idles low, so all nine init clocks are host pulses
    wr_enable <= 1'b0;
    rst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (PWR) @(posedge sys_clk);
    #1;
    chk_bit(bidir_mode, 1'b0);
    issue(DMSEP_OP_TXO, 7'h00, 8'h00);
    for (i = 0; i < 9; i++)
      get_rise(b);
    chk_bit(b, 1'b1);
    for (j = 0; j < 3; j++)
    begin
      for (i = 7; i >= 0; i--)
      begin
        get_rise(b);
        chk_bit(b, stream[j][i]);
      end
      get_rise(b);
      chk_bit(b, 1'b1);
    end
    chk_bit(bidir_mode, 1'b0);
    $display("stream test finished");
    end_of_test();
  end
endmodule
